// ### shared/lcd_cmd_pkg.sv
// Constants for the display module command handler: command and answer
// codes, field limits, timing in milliseconds and the register map.
// Assumes the packet framer outside has checked framing and CRC.
package lcd_cmd_pkg;
	// ----------------------------------------------------------------
	// Command types and answer flags
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_REBOOT    = 8'h05;
	localparam logic [7:0] CMD_CLEAR     = 8'h06;
	localparam logic [7:0] CMD_LINE_TOP  = 8'h07;
	localparam logic [7:0] CMD_LINE_BOT  = 8'h08;
	localparam logic [7:0] CMD_GLYPH     = 8'h09;
	localparam logic [7:0] CMD_MEM_READ  = 8'h0a;
	localparam logic [7:0] CMD_CUR_POS   = 8'h0b;
	localparam logic [7:0] CMD_CUR_STYLE = 8'h0c;
	localparam logic [7:0] CMD_CONTRAST  = 8'h0d;
	localparam logic [7:0] CMD_BACKLIGHT = 8'h0e;
	localparam logic [7:0] CMD_FAN_REP   = 8'h10;
	localparam logic [7:0] RSP_FLAG      = 8'h40;
	localparam logic [7:0] ERR_FLAG      = 8'hc0;
	localparam logic [4:0] MEM_READ_LEN  = 5'h09;
	// Key bytes of the three reboot variants
	localparam logic [23:0] KEY_REBOOT   = {8'h63, 8'h12, 8'h08};
	localparam logic [23:0] KEY_HOST_RST = {8'h61, 8'h1c, 8'h0c};
	localparam logic [23:0] KEY_HOST_OFF = {8'h5f, 8'h0b, 8'h03};
	// ----------------------------------------------------------------
	// Memory layout and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] BLANK_CHAR    = 8'h20;
	localparam int         LINE_CHARS    = 20;
	localparam int         CENTRE_OFS    = 2;
	localparam int         CHAR_CELLS    = 40;
	localparam int         GLYPH_BYTES   = 64;
	localparam logic [7:0] CONTRAST_MAX  = 8'h32;
	localparam logic [7:0] BACKLIGHT_MAX = 8'h64;
	localparam logic [7:0] FULL_POWER    = 8'h64;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ        = 40000000;
	localparam int          TICK_CYCLES   = CLK_HZ / 1000;
	localparam logic [15:0] HOST_RST_MS   = 16'h05dc;
	localparam logic [15:0] BOOT_BASE_MS  = 16'h012c;
	localparam logic [15:0] STAGGER_MS    = 16'h01f4;
	localparam logic [8:0]  REPORT_MS     = 9'h1f4;
	localparam logic [8:0]  SLOT_MS       = 9'h07d;
	// ----------------------------------------------------------------
	// Register map and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_STATUS    = 8'h00;
	localparam logic [7:0]  OFS_FAN_PWR   = 8'h04;
	localparam logic [7:0]  OFS_PULSE     = 8'h08;
	localparam logic [7:0]  OFS_SETTINGS  = 8'h0c;
	localparam logic [31:0] RST_FAN_PWR   = 32'h64646464;
	localparam logic [15:0] RST_PULSE_MS  = 16'h03e8;
	localparam logic [7:0]  RST_CONTRAST  = 8'h10;
	localparam logic [7:0]  RST_BACKLIGHT = 8'h64;

	typedef enum logic [2:0] {
		ST_BOOT = 3'b000,
		ST_IDLE = 3'b001,
		ST_ACK  = 3'b010,
		ST_HRST = 3'b011,
		ST_HPWR = 3'b100
	} seq_state_t;
endpackage

// ### design/lcd_cmd_handler.sv
// Command handler of a character display module: takes decoded command
// packets, keeps display state, answers each packet, runs host control.
// Assumes framed, CRC-checked packets and an APB master for setup.
// Overview of operation
// - Every command gets answer or error packet
// - Answer keeps low 6 type bits
// - Ack, host reset, reboot, then busy
// - Ack, power pulse, reboot, then busy
// - Reboot variants answered with 0x45
// - Fans switched on one by one
// - Clear fills blanks, cursor home
// - Top line takes sixteen centre characters
// - Bottom line takes sixteen centre characters
// - Glyph index then eight rows stored
// - Glyph rows six bits, top first
// - Memory read returns address and eight bytes
// - Cursor column 0-15, row 0-1
// - Cursor style one of four
// - Contrast 0 to 50 applied
// - Backlight 0 to 100 applied
// - Fan report mask 0 to 15
// - Fan reports every 500 ms, staggered
// - Reported fan forced full per slot
// - Command state kept as boot state, except the fan report mask
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module lcd_cmd_handler #(
	parameter int TICK_CYCLES = lcd_cmd_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Command packets in
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire logic [7:0]   cmd_type,
	input  wire logic [4:0]   cmd_len,
	input  wire logic [127:0] cmd_data,
	// Answer packets out
	output logic              rsp_valid,
	input  wire logic         rsp_ready,
	output logic      [7:0]   rsp_type,
	output logic      [4:0]   rsp_len,
	output logic      [71:0]  rsp_data,
	// Fan speed report strobes
	output logic              report_valid,
	output logic      [1:0]   report_fan,
	// Display and fan controls
	output logic      [7:0]   contrast,
	output logic      [7:0]   backlight,
	output logic      [3:0]   cursor_col,
	output logic              cursor_row,
	output logic      [1:0]   cursor_style,
	output logic      [31:0]  fan_pwr,
	output logic      [3:0]   fan_force,
	// Host control
	output logic              host_rst_out,
	output logic              host_pwr_out,
	output logic              busy
);
	import lcd_cmd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  char_mem  [0:CHAR_CELLS-1];  // display_char_memory
	logic [7:0]  glyph_mem [0:GLYPH_BYTES-1]; // glyph_pattern_memory
	seq_state_t  state_reg;
	logic [1:0]  kind_reg;
	logic [15:0] seq_ms_reg;
	logic [2:0]  boot_fan_reg;
	logic        seen_reg;
	logic [3:0]  fan_on_reg;
	logic [3:0]  fan_mask_reg;
	logic [8:0]  rep_ms_reg;
	logic [15:0] tick_reg;
	logic        ms_tick;
	logic [31:0] fan_cfg_reg;
	logic [15:0] pulse_ms_reg;
	logic        accept;
	logic        cmd_ok;
	logic [7:0]  b [0:15];
	logic [71:0] rd_bytes;
	logic [1:0]  slot;

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			b[i] = cmd_data[8*i +: 8];
		end
	end

	// Commands are refused by back-pressure while busy or answer pending
	assign cmd_ready = (state_reg == ST_IDLE) && !rsp_valid;
	assign accept    = cmd_valid && cmd_ready;
	assign busy      = (state_reg != ST_IDLE);
	assign host_rst_out = (state_reg == ST_HRST);
	assign host_pwr_out = (state_reg == ST_HPWR);

	// ----------------------------------------------------------------
	// Command checking
	// ----------------------------------------------------------------
	// Range checks guard every state change; a failing packet is answered
	// with an error and nothing is touched
	always_comb begin
		cmd_ok = 1'b0;
		case (cmd_type)
			CMD_REBOOT: cmd_ok = (cmd_len == 5'd3) &&
				({b[2], b[1], b[0]} == KEY_REBOOT ||
				 {b[2], b[1], b[0]} == KEY_HOST_RST ||
				 {b[2], b[1], b[0]} == KEY_HOST_OFF);
			CMD_CLEAR:    cmd_ok = (cmd_len == 5'd0);
			CMD_LINE_TOP: cmd_ok = (cmd_len == 5'd16);
			CMD_LINE_BOT: cmd_ok = (cmd_len == 5'd16);
			CMD_GLYPH: begin
				cmd_ok = (cmd_len == 5'd9) && (b[0] < 8'd8);
				for (int i = 1; i < 9; i++) begin
					if (b[i][7:6] != 2'b00) begin
						cmd_ok = 1'b0;
					end
				end
			end
			CMD_MEM_READ: cmd_ok = (cmd_len == 5'd1) &&
				((b[0][7:6] == 2'b01) ||
				 (b[0][7] && !b[0][5] &&
				  b[0][4:0] < 5'(LINE_CHARS)));
			CMD_CUR_POS: cmd_ok = (cmd_len == 5'd2) && (b[0] < 8'd16) &&
				(b[1] < 8'd2);
			CMD_CUR_STYLE: cmd_ok = (cmd_len == 5'd1) &&
				(b[0] < 8'd4);
			CMD_CONTRAST: cmd_ok = (cmd_len == 5'd1) &&
				(b[0] <= CONTRAST_MAX);
			CMD_BACKLIGHT: cmd_ok = (cmd_len == 5'd1) &&
				(b[0] <= BACKLIGHT_MAX);
			CMD_FAN_REP: cmd_ok = (cmd_len == 5'd1) &&
				(b[0] < 8'd16);
			default: cmd_ok = 1'b0;
		endcase
	end

	// Byte at a native address code; codes past a line read as zero
	function automatic logic [7:0] mem_byte(input logic [7:0] a);
		logic [5:0] idx;
		idx = a[6] ? 6'(LINE_CHARS) + {1'b0, a[4:0]} : {1'b0, a[4:0]};
		if (a[7:6] == 2'b01) begin
			return glyph_mem[a[5:0]];
		end else if (a[7] && !a[5] && a[4:0] < 5'(LINE_CHARS)) begin
			return char_mem[idx];
		end
		return 8'h00;
	endfunction

	// Echoed address then eight bytes from the read address onward
	always_comb begin
		rd_bytes = '0;
		rd_bytes[7:0] = b[0];
		for (int i = 0; i < 8; i++) begin
			rd_bytes[8*(i+1) +: 8] = mem_byte(b[0] + 8'(i));
		end
	end

	// ----------------------------------------------------------------
	// Answer channel
	// ----------------------------------------------------------------
	// One answer per accepted packet, held until the framer takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid <= 1'b0;
			rsp_type  <= 8'h00;
			rsp_len   <= 5'h00;
			rsp_data  <= '0;
		end else if (accept) begin
			rsp_valid <= 1'b1;
			rsp_type  <= {2'b00, cmd_type[5:0]} |
				(cmd_ok ? RSP_FLAG : ERR_FLAG);
			rsp_len   <= 5'h00;
			rsp_data  <= '0;
			if (cmd_ok && cmd_type == CMD_MEM_READ) begin
				rsp_len  <= MEM_READ_LEN;
				rsp_data <= rd_bytes;
			end
		end else if (rsp_ready) begin
			rsp_valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Display memories
	// ----------------------------------------------------------------
	// Contents survive a module reboot, as a stored boot state would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < CHAR_CELLS; i++) begin
				char_mem[i] <= BLANK_CHAR;
			end
			for (int i = 0; i < GLYPH_BYTES; i++) begin
				glyph_mem[i] <= 8'h00;
			end
		end else if (accept && cmd_ok) begin
			case (cmd_type)
				CMD_CLEAR: begin
					for (int i = 0; i < CHAR_CELLS; i++) begin
						char_mem[i] <= BLANK_CHAR;
					end
				end
				CMD_LINE_TOP: begin
					for (int i = 0; i < 16; i++) begin
						char_mem[CENTRE_OFS + i] <= b[i];
					end
				end
				CMD_LINE_BOT: begin
					for (int i = 0; i < 16; i++) begin
						char_mem[LINE_CHARS + CENTRE_OFS + i] <= b[i];
					end
				end
				CMD_GLYPH: begin
					for (int i = 0; i < 8; i++) begin
						glyph_mem[{b[0][2:0], 3'(i)}] <= b[i+1];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contrast     <= RST_CONTRAST;
			backlight    <= RST_BACKLIGHT;
			cursor_col   <= 4'h0;
			cursor_row   <= 1'b0;
			cursor_style <= 2'h0;
		end else if (accept && cmd_ok) begin
			case (cmd_type)
				CMD_CLEAR: begin
					cursor_col <= 4'h0;
					cursor_row <= 1'b0;
				end
				CMD_CUR_POS: begin
					cursor_col <= b[0][3:0];
					cursor_row <= b[1][0];
				end
				CMD_CUR_STYLE: cursor_style <= b[0][1:0];
				CMD_CONTRAST:  contrast     <= b[0];
				CMD_BACKLIGHT: backlight    <= b[0];
				default: begin
				end
			endcase
		end
	end

	// Millisecond tick; all slow timing counts these pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 16'h0000;
			ms_tick  <= 1'b0;
		end else begin
			ms_tick  <= (tick_reg == 16'(TICK_CYCLES - 1));
			tick_reg <= (tick_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000
				: tick_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Host control and boot sequence
	// ----------------------------------------------------------------
	// Power-up starts in boot; fans come on one at a time so their inrush
	// does not add up. Unpowered fans are skipped at no cost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_BOOT;
			kind_reg     <= 2'h0;
			seq_ms_reg   <= 16'h0000;
			boot_fan_reg <= 3'h0;
			seen_reg     <= 1'b0;
			fan_on_reg   <= 4'h0;
		end else begin
			if (ms_tick) begin
				seq_ms_reg <= seq_ms_reg + 16'h0001;
			end
			case (state_reg)
				ST_IDLE: begin
					if (accept && cmd_ok && cmd_type == CMD_REBOOT) begin
						state_reg <= ST_ACK;
						kind_reg  <= ({b[2], b[1], b[0]} == KEY_HOST_RST) ? 2'h1
							: ({b[2], b[1], b[0]} == KEY_HOST_OFF) ? 2'h2 : 2'h0;
					end
				end
				ST_ACK: begin
					// Host action only after the answer has left
					if (!rsp_valid) begin
						seq_ms_reg <= 16'h0000;
						state_reg  <= (kind_reg == 2'h1) ? ST_HRST
							: (kind_reg == 2'h2) ? ST_HPWR : ST_BOOT;
						boot_fan_reg <= 3'h0;
						seen_reg     <= 1'b0;
						fan_on_reg   <= 4'h0;
					end
				end
				ST_HRST, ST_HPWR: begin
					if (seq_ms_reg >= ((state_reg == ST_HRST) ? HOST_RST_MS
						: pulse_ms_reg)) begin
						state_reg    <= ST_BOOT;
						seq_ms_reg   <= 16'h0000;
						boot_fan_reg <= 3'h0;
						seen_reg     <= 1'b0;
						fan_on_reg   <= 4'h0;
					end
				end
				ST_BOOT: begin
					if (boot_fan_reg[2]) begin
						if (seq_ms_reg >= BOOT_BASE_MS) begin
							state_reg <= ST_IDLE;
						end
					end else if (fan_cfg_reg[8*boot_fan_reg[1:0] +: 8] == 8'h00) begin
						boot_fan_reg <= boot_fan_reg + 3'h1;
					end else if (!seen_reg || seq_ms_reg >= STAGGER_MS) begin
						fan_on_reg[boot_fan_reg[1:0]] <= 1'b1;
						seen_reg     <= 1'b1;
						seq_ms_reg   <= 16'h0000;
						boot_fan_reg <= boot_fan_reg + 3'h1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fan reporting
	// ----------------------------------------------------------------
	// Mask is not kept over a reboot; the host must enable it again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_mask_reg <= 4'h0;
		end else if (state_reg == ST_BOOT) begin
			fan_mask_reg <= 4'h0;
		end else if (accept && cmd_ok && cmd_type == CMD_FAN_REP) begin
			fan_mask_reg <= b[0][3:0];
		end
	end

	assign slot = (rep_ms_reg < SLOT_MS) ? 2'd0
		: (rep_ms_reg < 9'(2 * SLOT_MS)) ? 2'd1
		: (rep_ms_reg < 9'(3 * SLOT_MS)) ? 2'd2 : 2'd3;

	// Half-second frame cut into four eighth-second slots, one per fan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rep_ms_reg   <= 9'h000;
			report_valid <= 1'b0;
			report_fan   <= 2'h0;
		end else begin
			report_valid <= 1'b0;
			if (fan_mask_reg == 4'h0) begin
				rep_ms_reg <= 9'h000;
			end else if (ms_tick) begin
				rep_ms_reg <= (rep_ms_reg == REPORT_MS - 9'h001) ? 9'h000
					: rep_ms_reg + 9'h001;
				if (rep_ms_reg == 9'(SLOT_MS * slot) && fan_mask_reg[slot]) begin
					report_valid <= 1'b1;
					report_fan   <= slot;
				end
			end
		end
	end

	// Forced full power in the fan's own slot so its tach can be read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_force <= 4'h0;
			fan_pwr   <= 32'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				fan_force[k] <= fan_mask_reg[k] && (slot == 2'(k));
				fan_pwr[8*k +: 8] <= !fan_on_reg[k] ? 8'h00
					: fan_force[k] ? FULL_POWER : fan_cfg_reg[8*k +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_cfg_reg  <= RST_FAN_PWR;
			pulse_ms_reg <= RST_PULSE_MS;
		end else if (psel && penable && pwrite) begin
			if (paddr == OFS_FAN_PWR) begin
				fan_cfg_reg <= pwdata;
			end else if (paddr == OFS_PULSE) begin
				pulse_ms_reg <= pwdata[15:0];
			end
		end
	end

	always_comb begin
		prdata  = 32'h0;
		pslverr = 1'b0;
		case (paddr)
			OFS_STATUS:   prdata = {20'h0, fan_on_reg, fan_mask_reg,
				busy, state_reg};
			OFS_FAN_PWR:  prdata = fan_cfg_reg;
			OFS_PULSE:    prdata = {16'h0, pulse_ms_reg};
			OFS_SETTINGS: prdata = {6'h0, cursor_style, 3'h0, cursor_row,
				cursor_col, backlight, contrast};
			default:      pslverr = psel && penable;
		endcase
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [5:0] acc_low_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_low_q <= 6'h00;
		end else if (accept) begin
			acc_low_q <= cmd_type[5:0];
		end
	end

	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		accept |=> rsp_valid ##0 !cmd_ready;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");

	property p_low_bits;
		@(posedge pclk) disable iff (!presetn)
		accept |=> rsp_type[5:0] == acc_low_q;
	endproperty
	a_low_bits: assert property (p_low_bits) else $error("type bits");

	property p_reboot_ack;
		@(posedge pclk) disable iff (!presetn)
		(accept && cmd_ok && cmd_type == CMD_REBOOT) |=>
			rsp_type == 8'h45 && rsp_len == 5'h00;
	endproperty
	a_reboot_ack: assert property (p_reboot_ack) else $error("ack 45");

	property p_rst_after_ack;
		@(posedge pclk) disable iff (!presetn)
		$rose(host_rst_out) |-> !rsp_valid && $past(state_reg) == ST_ACK;
	endproperty
	a_rst_after_ack: assert property (p_rst_after_ack) else $error("early reset");

	property p_pwr_then_boot;
		@(posedge pclk) disable iff (!presetn)
		$fell(host_pwr_out) |-> state_reg == ST_BOOT && !cmd_ready;
	endproperty
	a_pwr_then_boot: assert property (p_pwr_then_boot) else $error("no reboot");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(accept && cmd_type == CMD_CLEAR && cmd_len == 5'd0) |=>
			cursor_col == 4'h0 && !cursor_row && rsp_type == 8'h46;
	endproperty
	a_clear: assert property (p_clear) else $error("clear");

	property p_contrast;
		@(posedge pclk) disable iff (!presetn)
		(accept && cmd_ok && cmd_type == CMD_CONTRAST) |=>
			contrast == $past(b[0]) && contrast <= CONTRAST_MAX;
	endproperty
	a_contrast: assert property (p_contrast) else $error("contrast");

	property p_bad_cmd;
		@(posedge pclk) disable iff (!presetn)
		(accept && !cmd_ok) |=> rsp_type[7:6] == 2'b11 &&
			$stable(contrast) && $stable(backlight) && $stable(cursor_col);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("bad cmd");

	property p_report;
		@(posedge pclk) disable iff (!presetn)
		report_valid |-> fan_mask_reg[report_fan] && fan_force[report_fan];
	endproperty
	a_report: assert property (p_report) else $error("report");

	property p_force;
		@(posedge pclk) disable iff (!presetn)
		(fan_force[0] && fan_on_reg[0]) |=> fan_pwr[7:0] == FULL_POWER;
	endproperty
	a_force: assert property (p_force) else $error("force");

	c_mem_read: cover property (@(posedge pclk) disable iff (!presetn)
		accept && cmd_ok && cmd_type == CMD_MEM_READ);
	c_host_rst: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(host_rst_out));
	c_report: cover property (@(posedge pclk) disable iff (!presetn)
		report_valid && report_fan == 2'd3);
endmodule

// ### bench/pkt_host.sv
// Host model: offers command packets and takes the answers.
// Assumes the handler's valid/ready handshake on one clock.
`timescale 1ns/1ps
module pkt_host (
	// Clock
	input  wire logic         pclk,
	// Command packets out
	output logic              cmd_valid,
	input  wire logic         cmd_ready,
	output logic      [7:0]   cmd_type,
	output logic      [4:0]   cmd_len,
	output logic      [127:0] cmd_data,
	// Answer packets in
	input  wire logic         rsp_valid,
	output logic              rsp_ready,
	input  wire logic [7:0]   rsp_type,
	input  wire logic [4:0]   rsp_len,
	input  wire logic [71:0]  rsp_data
);
	int slow = 0;
	// Idle fields start defined
	initial begin
		cmd_valid = 1'b0;
		rsp_ready = 1'b0;
		cmd_type = 8'h00;
		cmd_len = 5'h00;
		cmd_data = '0;
	end
	// One command, then its answer; slow stalls the answer side
	task automatic xfer(input logic [7:0] t, input logic [4:0] l,
		input logic [127:0] d, output logic [7:0] rt,
		output logic [4:0] rl, output logic [71:0] rd);
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_type <= t;
		cmd_len <= l;
		cmd_data <= d;
		// Level seen at the falling edge holds to the taking edge
		repeat (20000) begin
			@(negedge pclk);
			if (cmd_ready) break;
		end
		@(posedge pclk);
		cmd_valid <= 1'b0;
		cmd_data <= ~d; // Released fields must not look valid
		repeat (20000) begin
			@(negedge pclk);
			if (rsp_valid) break;
		end
		rt = rsp_type;
		rl = rsp_len;
		rd = rsp_data;
		// Seen at a falling edge; ready rises only after a rising edge
		repeat (slow + 1) @(posedge pclk);
		rsp_ready <= 1'b1;
		@(posedge pclk);
		rsp_ready <= 1'b0;
	endtask
endmodule

// ### bench/lcd_module_command_handler_tb.sv
// Self-checking bench of the command handler, short ms tick.
// Assumes the host model and the handler's package.
`timescale 1ns/1ps
module lcd_module_command_handler_tb;
	import lcd_cmd_pkg::*;
	typedef struct {logic [7:0] t; logic [4:0] l; logic [127:0] d;
		logic [7:0] e;} row_t;
	localparam logic [127:0] TXT = 128'h504f4e4d4c4b4a494847464544434241;
	localparam logic [71:0] MEM = 72'h464544434241202080;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic pready, pslverr, report_valid, cursor_row, rerr;
	logic host_rst_out, host_pwr_out, busy;
	logic [7:0] paddr = 8'h00, cmd_type, rsp_type, contrast, backlight;
	logic [31:0] pwdata = 32'h0, prdata, fan_pwr, rdat;
	logic [4:0] cmd_len, rsp_len, rl;
	logic [127:0] cmd_data;
	logic [71:0] rsp_data, rd;
	logic [7:0] rt;
	logic [3:0] cursor_col, fan_force, seen, forced;
	logic [1:0] report_fan, cursor_style;
	int mismatches = 0, n_checks = 0, cyc = 0, nr, np;
	row_t rows[14] = '{'{8'h0b, 2, 16'h010f, 8'h4b},
		'{8'h0b, 2, 16'h0110, 8'hcb}, '{8'h0c, 1, 3, 8'h4c},
		'{8'h0d, 1, 8'h32, 8'h4d}, '{8'h0d, 1, 8'h33, 8'hcd},
		'{8'h0e, 1, 0, 8'h4e}, '{8'h0e, 1, 8'h65, 8'hce},
		'{8'h09, 9, 72'h080706050403020107, 8'h49},
		'{8'h09, 9, 72'h400706050403020107, 8'hc9},
		'{8'h07, 15, TXT, 8'hc7}, '{8'h06, 0, 0, 8'h46},
		'{8'h07, 16, TXT, 8'h47}, '{8'h08, 16, TXT, 8'h48},
		'{8'h0a, 1, 8'h94, 8'hca}};

	always #12.5 pclk = ~pclk;

	lcd_cmd_handler #(.TICK_CYCLES(4)) u_dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cmd_valid, .cmd_ready, .cmd_type, .cmd_len, .cmd_data,
		.rsp_valid, .rsp_ready, .rsp_type, .rsp_len, .rsp_data,
		.report_valid, .report_fan, .contrast, .backlight, .cursor_col,
		.cursor_row, .cursor_style, .fan_pwr, .fan_force, .host_rst_out,
		.host_pwr_out, .busy);
	pkt_host u_host (.pclk, .cmd_valid, .cmd_ready, .cmd_type, .cmd_len,
		.cmd_data, .rsp_valid, .rsp_ready, .rsp_type, .rsp_len,
		.rsp_data);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmd(logic [7:0] t, logic [4:0] l, logic [127:0] d,
		logic [7:0] e);
		u_host.xfer(t, l, d, rt, rl, rd);
		chk("rsp_type", e, rt);
	endtask
	// APB: setup, access until pready, then release
	task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Host-control cycles seen until the module is free again
	task automatic watch();
		nr = 0;
		np = 0;
		repeat (20000) begin
			@(negedge pclk);
			if (busy === 1'b0) break;
			nr += int'(host_rst_out);
			np += int'(host_pwr_out);
		end
	endtask

	// Hang guard: whole run is about 20k cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk("contrast", 8'h10, contrast);
		watch();
		chk("fan_pwr", 32'h64646464, fan_pwr);
		foreach (rows[i]) begin
			u_host.slow = i % 3;
			cmd(rows[i].t, rows[i].l, rows[i].d, rows[i].e);
		end
		chk("settings", {cursor_style, cursor_row, cursor_col},
			7'h60);
		chk("contrast", 8'h32, contrast);
		chk("backlight", 8'h00, backlight);
		cmd(8'h0a, 1, 8'h80, 8'h4a);
		chk("mem_line", MEM, rd);
		chk("rsp_len", MEM_READ_LEN, rl);
		cmd(8'h0a, 1, 8'h78, 8'h4a);
		chk("mem_glyph", 72'h080706050403020178, rd);
		apb(1'b1, OFS_PULSE, 32'h0000000a);
		apb(1'b1, OFS_FAN_PWR, 32'h00000064);
		apb(1'b0, OFS_PULSE, 32'h0);
		chk("pulse", 32'h0000000a, rdat);
		apb(1'b0, 8'h10, 32'h0);
		chk("pslverr", 1'b1, rerr);
		cmd(8'h10, 1, 8'h05, 8'h50);
		seen = 4'h0;
		forced = 4'h0;
		// A bit over one frame: the first slot-0 report may come early
		repeat (2100) begin
			@(negedge pclk);
			forced |= fan_force;
			if (report_valid === 1'b1) seen[report_fan] = 1'b1;
		end
		chk("reports", 4'h5, seen);
		chk("forced", 4'h5, forced);
		cmd(8'h05, 3, 24'h611c0c, 8'h45);
		chk("rsp_len", 5'h00, rl);
		watch();
		// Tick phase moves the end by a few cycles, so round to a ms
		chk("rst_ms", HOST_RST_MS, (nr + 2) / 4);
		chk("fan_pwr", 32'h00000064, fan_pwr);
		cmd(8'h05, 3, 24'h5f0b03, 8'h45);
		watch();
		chk("pwr_ms", 10, (np + 2) / 4);
		chk("rst_off", 0, nr);
		cmd(8'h0a, 1, 8'h80, 8'h4a);
		chk("mem_kept", MEM, rd);
		close_out();
	end
endmodule
